/* video_stream_throttle_port_bench.sv */
`timescale 1ns/1ps
module video_stream_throttle_port_bench;
    localparam int BPC = 10;
    localparam int PW = BPC * 3;
    localparam int TDW = ((PW + 7) / 8) * 8;
    localparam int COLS = 8;
    localparam int CYC_MAX = 20000;
    localparam logic [TDW-1:0] MASK = TDW'((64'h1 << PW) - 1);
    logic clk_sys = 1'b0;
    logic core_reset_low = 1'b0;
    logic [TDW-1:0] s_tdata = '0, m_tdata, cur_d = '0;
    logic s_tvalid = 1'b0, s_tuser = 1'b0, s_tlast = 1'b0, s_tready;
    logic m_tvalid, m_tready, m_tuser, m_tlast, irq;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, sink_mode = 2'h0;
    logic [TDW+1:0] exp_q[$];
    logic [TDW+1:0] e;
    int mismatches = 0, compares = 0, cyc = 0, k;
    realtime t_acc, t_first;
    bit took;

    always #2 clk_sys = ~clk_sys;

    vstp_top #(.PPC(1), .BPC(BPC), .COLS(COLS), .ROWS(2)) u_vstp_top (
        .clk_sys(clk_sys), .core_reset_low(core_reset_low),
        .s_axis_video_tdata(s_tdata), .s_axis_video_tvalid(s_tvalid),
        .s_axis_video_tready(s_tready), .s_axis_video_tuser(s_tuser),
        .s_axis_video_tlast(s_tlast), .m_axis_video_tdata(m_tdata),
        .m_axis_video_tvalid(m_tvalid), .m_axis_video_tready(m_tready),
        .m_axis_video_tuser(m_tuser), .m_axis_video_tlast(m_tlast),
        .s_axi_ctrl_awaddr(awaddr), .s_axi_ctrl_awvalid(awvalid),
        .s_axi_ctrl_awready(awready), .s_axi_ctrl_wdata(wdata),
        .s_axi_ctrl_wstrb(4'hf), .s_axi_ctrl_wvalid(wvalid),
        .s_axi_ctrl_wready(wready), .s_axi_ctrl_bresp(bresp),
        .s_axi_ctrl_bvalid(bvalid), .s_axi_ctrl_bready(1'b1),
        .s_axi_ctrl_araddr(araddr), .s_axi_ctrl_arvalid(arvalid),
        .s_axi_ctrl_arready(arready), .s_axi_ctrl_rdata(rdata),
        .s_axi_ctrl_rresp(rresp), .s_axi_ctrl_rvalid(rvalid),
        .s_axi_ctrl_rready(1'b1), .interrupt(irq)
    );

    vstp_sink_model u_vstp_sink_model (
        .clk_sys(clk_sys), .mode(sink_mode), .tready(m_tready)
    );

    // ****************************************
    // compare, watch and close
    // ****************************************
    task automatic check_word(input string what, input logic [63:0] ex, input logic [63:0] got);
        compares++;
        if (got !== ex) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, ex, got);
        end
    endtask : check_word

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == CYC_MAX) begin
            mismatches++;
            tally_and_finish();
        end else if (core_reset_low === 1'b1 && m_tvalid === 1'b1 && m_tready === 1'b1) begin
            if (exp_q.size() == 0) begin
                check_word("spare beat", 64'h0, 64'h1);
            end else begin
                e = exp_q.pop_front();
                check_word("tdata", 64'(e[TDW-1:0]), 64'(m_tdata));
                check_word("tuser", 64'(e[TDW]), 64'(m_tuser));
                check_word("tlast", 64'(e[TDW+1]), 64'(m_tlast));
            end
        end
    end

    // ****************************************
    // drivers
    // ****************************************
    // one cycle of offer; data held until taken
    task automatic offer(input logic u, input logic l, output bit tk);
        @(negedge clk_sys);
        s_tdata = cur_d;
        s_tuser = u;
        s_tlast = l;
        s_tvalid = 1'b1;
        tk = (s_tready === 1'b1);
        @(posedge clk_sys);
        if (tk) begin
            exp_q.push_back({l, u, cur_d & MASK});
            t_acc = $realtime;
            cur_d = TDW'($urandom);
        end
    endtask : offer

    task automatic send(input logic u, input logic l);
        int n;
        bit tk;
        n = 0;
        tk = 1'b0;
        while (!tk && n < 100) begin
            offer(u, l, tk);
            n++;
        end
        check_word("taken", 64'h1, 64'(tk));
    endtask : send

    task automatic send_line(input logic sof);
        for (int i = 0; i < COLS; i++) begin
            send(sof && i == 0, i == COLS - 1);
            if (i == 0) t_first = t_acc;
        end
    endtask : send_line

    task automatic drain();
        int n;
        @(negedge clk_sys);
        s_tvalid = 1'b0;
        n = 0;
        while (exp_q.size() != 0 && n < 300) begin
            @(negedge clk_sys);
            n++;
        end
        check_word("left in queue", 64'h0, 64'(exp_q.size()));
    endtask : drain

    task automatic lite_rw(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(negedge clk_sys);
        awaddr = a;
        wdata = d;
        awvalid = 1'b1;
        wvalid = 1'b1;
        araddr = ~a;
        arvalid = 1'b1;
        #1;
        n = 0;
        while ((awready !== 1'b1 || arready !== 1'b1) && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        check_word("wready", 64'h1, 64'(wready));
        check_word("arready", 64'h1, 64'(arready));
        @(posedge clk_sys);
        @(negedge clk_sys);
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        check_word("bvalid", 64'h1, 64'(bvalid));
        check_word("bresp", 64'h0, 64'(bresp));
        check_word("rvalid", 64'h1, 64'(rvalid));
        check_word("rdata rresp", 64'h0, {rdata, rresp});
    endtask : lite_rw

    // ****************************************
    // tests
    // ****************************************
    initial begin
        realtime t_line;
        void'($urandom(32'h3173));
        repeat (2) @(negedge clk_sys);
        check_word("tvalid in reset", 64'h0, 64'(m_tvalid));
        core_reset_low = 1'b1;
        check_word("interrupt", 64'h0, 64'(irq));
        $display("test reset done");

        send_line(1'b1);
        t_line = t_first;
        send_line(1'b0);
        check_word("line cycles", 64'(COLS + 17), 64'(int'((t_first - t_line) / 4)));
        drain();
        $display("test line rate done");

        sink_mode = 2'h2;
        for (int j = 0; j < 3; j++) send_line(j == 0);
        drain();
        $display("test random stall done");

        sink_mode = 2'h1;
        k = 0;
        for (int j = 0; j < 30; j++) begin
            offer(1'b0, 1'b0, took);
            k += int'(took);
        end
        check_word("tready full", 64'h0, 64'(s_tready));
        check_word("beats held", 64'h1, 64'(k >= 8));
        sink_mode = 2'h0;
        send(1'b0, 1'b1);
        drain();
        repeat (4) @(negedge clk_sys);
        check_word("tvalid drained", 64'h0, 64'(m_tvalid));
        $display("test backpressure done");

        sink_mode = 2'h1;
        repeat (4) offer(1'b1, 1'b0, took);
        @(negedge clk_sys);
        core_reset_low = 1'b0;
        @(negedge clk_sys);
        check_word("tvalid reset", 64'h0, 64'(m_tvalid));
        s_tvalid = 1'b0;
        @(negedge clk_sys);
        exp_q.delete();
        core_reset_low = 1'b1;
        sink_mode = 2'h0;
        send_line(1'b1);
        drain();
        $display("test mid line reset done");

        for (int j = 0; j < 3; j++) lite_rw(8'($urandom), $urandom);
        check_word("interrupt", 64'h0, 64'(irq));
        $display("test control done");
        tally_and_finish();
    end
endmodule : video_stream_throttle_port_bench

/* vstp_defs.svh */
// Behaviour
// - both streams use the video stream handshake; control port uses the lite handshake.
// - output valid stops once buffering drains while input valid is withheld.
// - input ready stays low once buffering is full while output ready is withheld.
// - each transfer moves one, two or four pixels as built.
// - after each line and frame end, input ready is low seventeen cycles: seven of flush, then ten of gap.
// - per-line overhead is seventeen cycles with an always-valid source.
// - control port always present; stream input is a build option.
// - one-bit interrupt output exists, carries nothing, reserved.
// - one clock and one reset drive the core and all interfaces.
// - all stream and control inputs sampled on the rising clock edge.
// - stream outputs come from registers clocked on the rising edge.
// - reset is active low, synchronous, acting at the next rising edge.
// - user marks first pixel of a frame; last marks final pixel of a line.
// - data words are whole bytes, unused upper bits zero.
`ifndef VSTP_DEFS_SVH
`define VSTP_DEFS_SVH
`define VSTP_FLUSH_CYC 5'h07
`define VSTP_LINE_OVH 5'h11
`define VSTP_FIFO_DEPTH 8
`define VSTP_COLS 1920
`define VSTP_ROWS 1080
`define VSTP_PPC 1
`define VSTP_BPC 8
`define VSTP_NCOMP 3
`define VSTP_CTRL_AW 8
`define VSTP_RESP_OKAY 2'h0
`define VSTP_CNT_W 5
`endif

/* vstp_fifo.sv */
`timescale 1ns/1ps
module vstp_fifo #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8,
    parameter int AW = $clog2(DEPTH),
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_sys,
    input wire logic core_reset_low,
    vstp_strm_if.snk wr,
    vstp_strm_if.src rd,
    output logic [CW-1:0] level
);
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    logic fresh_ff;
    logic push;
    logic pop;
    logic [AW-1:0] raddr;

    // full stalls the source side
    assign wr.ready = (count_ff != CW'(DEPTH));
    assign push = wr.valid && wr.ready;
    // read register lags a write to the same word by one cycle
    assign rd.valid = (count_ff != '0) && fresh_ff;
    assign pop = rd.valid && rd.ready;
    assign raddr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    assign level = count_ff;

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
            fresh_ff <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            end
            rd_ptr_ff <= raddr;
            count_ff <= CW'(count_ff + CW'(push) - CW'(pop));
            fresh_ff <= !(push && (wr_ptr_ff == raddr));
        end
    end

    vstp_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_sys(clk_sys),
        .we(push),
        .waddr(wr_ptr_ff),
        .wdata(wr.data),
        .raddr(raddr),
        .rdata_ff(rd.data)
    );
endmodule : vstp_fifo

/* vstp_mem.sv */
`timescale 1ns/1ps
module vstp_mem #(
    parameter int WIDTH = 26,
    parameter int DEPTH = 8,
    parameter int AW = 3
) (
    input wire logic clk_sys,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata_ff
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        rdata_ff <= mem[raddr];
    end
endmodule : vstp_mem

/* vstp_pkg.sv */
package vstp_pkg;
    typedef enum logic [1:0] {
        VSTP_RUN = 2'h0,
        VSTP_FLUSH = 2'h1,
        VSTP_GAP = 2'h2
    } vstp_state_t;
endpackage : vstp_pkg

/* vstp_sink_model.sv */
`timescale 1ns/1ps
module vstp_sink_model (
    input wire logic clk_sys,
    input wire logic [1:0] mode,
    output logic tready
);
    // ****************************************
    // downstream sink: always, never or random
    // ****************************************
    // ready moves only off the sampling edge
    always @(negedge clk_sys) begin
        case (mode)
            2'h0: tready <= 1'b1;
            2'h1: tready <= 1'b0;
            default: tready <= 1'($urandom);
        endcase
    end
endmodule : vstp_sink_model

/* vstp_strm_if.sv */
`timescale 1ns/1ps
interface vstp_strm_if #(parameter int WIDTH = 26);
    logic [WIDTH-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : vstp_strm_if

/* vstp_top.sv */
`timescale 1ns/1ps
`include "vstp_defs.svh"
module vstp_top
    import vstp_pkg::*;
#(
    parameter int PPC = `VSTP_PPC,
    parameter int BPC = `VSTP_BPC,
    parameter int NCOMP = `VSTP_NCOMP,
    parameter int HAS_S_IN = 1,
    parameter int COLS = `VSTP_COLS,
    parameter int ROWS = `VSTP_ROWS,
    parameter int FIFO_DEPTH = `VSTP_FIFO_DEPTH,
    parameter int CAW = `VSTP_CTRL_AW,
    parameter int PW = BPC * NCOMP * PPC,
    parameter int TDW = ((PW + 7) / 8) * 8
) (
    input wire logic clk_sys,
    input wire logic core_reset_low,
    input wire logic [TDW-1:0] s_axis_video_tdata,
    input wire logic s_axis_video_tvalid,
    output logic s_axis_video_tready,
    input wire logic s_axis_video_tuser,
    input wire logic s_axis_video_tlast,
    output logic [TDW-1:0] m_axis_video_tdata,
    output logic m_axis_video_tvalid,
    input wire logic m_axis_video_tready,
    output logic m_axis_video_tuser,
    output logic m_axis_video_tlast,
    input wire logic [CAW-1:0] s_axi_ctrl_awaddr,
    input wire logic s_axi_ctrl_awvalid,
    output logic s_axi_ctrl_awready,
    input wire logic [31:0] s_axi_ctrl_wdata,
    input wire logic [3:0] s_axi_ctrl_wstrb,
    input wire logic s_axi_ctrl_wvalid,
    output logic s_axi_ctrl_wready,
    output logic [1:0] s_axi_ctrl_bresp,
    output logic s_axi_ctrl_bvalid,
    input wire logic s_axi_ctrl_bready,
    input wire logic [CAW-1:0] s_axi_ctrl_araddr,
    input wire logic s_axi_ctrl_arvalid,
    output logic s_axi_ctrl_arready,
    output logic [31:0] s_axi_ctrl_rdata,
    output logic [1:0] s_axi_ctrl_rresp,
    output logic s_axi_ctrl_rvalid,
    input wire logic s_axi_ctrl_rready,
    output logic interrupt
);
    // ********************************
    // constants
    // ********************************
    localparam int FW = TDW + 2;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int COLW = $clog2(COLS + 1);
    localparam int ROWW = $clog2(ROWS + 1);
    localparam logic [TDW-1:0] PAD_MASK = {TDW{1'b1}} >> (TDW - PW);
    localparam logic [`VSTP_CNT_W-1:0] FLUSH_LAST = `VSTP_FLUSH_CYC - 5'h01;
    localparam logic [`VSTP_CNT_W-1:0] GAP_LAST = `VSTP_LINE_OVH - `VSTP_FLUSH_CYC - 5'h01;
    localparam logic [COLW-1:0] BEATS_LAST = COLW'(COLS / PPC - 1);
    localparam logic [ROWW-1:0] ROWS_LAST = ROWW'(ROWS - 1);

    // ********************************
    // source selection
    // ********************************
    logic [TDW-1:0] src_data;
    logic src_valid;
    logic src_user;
    logic src_last;
    logic src_fire;
    logic in_ready;
    logic [CW-1:0] fifo_level;
    vstp_state_t st_ff;
    vstp_state_t nxt_st;
    logic [`VSTP_CNT_W-1:0] cnt_ff;
    logic [`VSTP_CNT_W-1:0] nxt_cnt;

    vstp_strm_if #(.WIDTH(FW)) fifo_in ();
    vstp_strm_if #(.WIDTH(FW)) fifo_out ();

    // flush and line gap block intake
    assign in_ready = (st_ff == VSTP_RUN) && fifo_in.ready;
    assign src_fire = src_valid && in_ready;

    generate
        if (HAS_S_IN != 0) begin : g_s_in
            // inputs taken at the rising edge of the one core clock
            assign src_data = s_axis_video_tdata & PAD_MASK;
            assign src_valid = s_axis_video_tvalid;
            assign src_user = s_axis_video_tuser;
            assign src_last = s_axis_video_tlast;
            assign s_axis_video_tready = in_ready;
        end else begin : g_no_s_in
            // internal always-valid blank source when input is not built
            logic [COLW-1:0] col_ff;
            logic [ROWW-1:0] row_ff;

            always_ff @(posedge clk_sys) begin
                if (!core_reset_low) begin
                    col_ff <= '0;
                    row_ff <= '0;
                end else if (src_fire) begin
                    if (col_ff == BEATS_LAST) begin
                        col_ff <= '0;
                        row_ff <= (row_ff == ROWS_LAST) ? '0 : ROWW'(row_ff + 1'b1);
                    end else begin
                        col_ff <= COLW'(col_ff + 1'b1);
                    end
                end
            end

            assign src_data = '0;
            assign src_valid = 1'b1;
            assign src_user = (col_ff == '0) && (row_ff == '0);
            assign src_last = (col_ff == BEATS_LAST);
            assign s_axis_video_tready = 1'b0;
        end
    endgenerate

    // each beat holds PPC pixels side by side
    assign fifo_in.data = {src_user, src_last, src_data};
    assign fifo_in.valid = src_valid && (st_ff == VSTP_RUN);

    // ********************************
    // line end flush and gap
    // ********************************
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            VSTP_RUN: begin
                if (src_fire && src_last) begin
                    nxt_st = VSTP_FLUSH;
                    nxt_cnt = FLUSH_LAST;
                end
            end
            VSTP_FLUSH: begin
                if (cnt_ff == '0) begin
                    nxt_st = VSTP_GAP;
                    nxt_cnt = GAP_LAST;
                end else begin
                    nxt_cnt = cnt_ff - 5'h01;
                end
            end
            VSTP_GAP: begin
                if (cnt_ff == '0) begin
                    nxt_st = VSTP_RUN;
                end else begin
                    nxt_cnt = cnt_ff - 5'h01;
                end
            end
            default: begin
                nxt_st = VSTP_RUN;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            st_ff <= VSTP_RUN;
            cnt_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
        end
    end

    // ********************************
    // eight word buffer
    // ********************************
    vstp_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .core_reset_low(core_reset_low),
        .wr(fifo_in.snk),
        .rd(fifo_out.src),
        .level(fifo_level)
    );

    // ********************************
    // registered output stage
    // ********************************
    assign fifo_out.ready = !m_axis_video_tvalid || m_axis_video_tready;

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            m_axis_video_tvalid <= 1'b0;
        end else if (fifo_out.ready) begin
            m_axis_video_tvalid <= fifo_out.valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            m_axis_video_tdata <= '0;
            m_axis_video_tuser <= 1'b0;
            m_axis_video_tlast <= 1'b0;
        end else if (fifo_out.ready && fifo_out.valid) begin
            m_axis_video_tdata <= fifo_out.data[TDW-1:0] & PAD_MASK;
            m_axis_video_tlast <= fifo_out.data[TDW];
            m_axis_video_tuser <= fifo_out.data[TDW+1];
        end
    end

    // ********************************
    // control port
    // ********************************
    // no software registers: writes acknowledged, reads return zero
    assign s_axi_ctrl_awready = s_axi_ctrl_awvalid && s_axi_ctrl_wvalid && !s_axi_ctrl_bvalid;
    assign s_axi_ctrl_wready = s_axi_ctrl_awready;
    assign s_axi_ctrl_arready = !s_axi_ctrl_rvalid;
    assign s_axi_ctrl_bresp = `VSTP_RESP_OKAY;
    assign s_axi_ctrl_rresp = `VSTP_RESP_OKAY;
    assign s_axi_ctrl_rdata = 32'h0000_0000;

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            s_axi_ctrl_bvalid <= 1'b0;
        end else if (s_axi_ctrl_awready) begin
            s_axi_ctrl_bvalid <= 1'b1;
        end else if (s_axi_ctrl_bready) begin
            s_axi_ctrl_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!core_reset_low) begin
            s_axi_ctrl_rvalid <= 1'b0;
        end else if (s_axi_ctrl_arvalid && s_axi_ctrl_arready) begin
            s_axi_ctrl_rvalid <= 1'b1;
        end else if (s_axi_ctrl_rready) begin
            s_axi_ctrl_rvalid <= 1'b0;
        end
    end

    // reserved request line, never raised
    assign interrupt = 1'b0;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!core_reset_low);

    property p_flush_len;
        src_fire && src_last |=> (!in_ready)[*7];
    endproperty
    a_flush_len: assert property (p_flush_len) else $error("input ready high in flush");

    property p_line_ovh;
        src_fire && src_last |=> (st_ff != VSTP_RUN)[*8] ##1 (st_ff != VSTP_RUN)[*8]
            ##1 (st_ff != VSTP_RUN) ##1 (st_ff == VSTP_RUN);
    endproperty
    a_line_ovh: assert property (p_line_ovh) else $error("line overhead not 17 cycles");

    property p_full_stall;
        (fifo_level == CW'(FIFO_DEPTH)) |-> !in_ready;
    endproperty
    a_full_stall: assert property (p_full_stall) else $error("ready high when full");

    property p_drain;
        m_axis_video_tvalid && m_axis_video_tready && (fifo_level == '0) |=> !m_axis_video_tvalid;
    endproperty
    a_drain: assert property (p_drain) else $error("output valid after drain");

    property p_out_hold;
        m_axis_video_tvalid && !m_axis_video_tready |=> m_axis_video_tvalid
            && $stable(m_axis_video_tdata) && $stable(m_axis_video_tlast)
            && $stable(m_axis_video_tuser);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("output changed while stalled");

    property p_reset_out;
        $rose(core_reset_low) |-> !m_axis_video_tvalid && !fifo_out.valid && (st_ff == VSTP_RUN);
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("state not cleared by reset");

    property p_pad_zero;
        m_axis_video_tvalid |-> (m_axis_video_tdata & ~PAD_MASK) == '0;
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");

    property p_irq_idle;
        interrupt == 1'b0;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("reserved interrupt raised");

    property p_wr_resp;
        s_axi_ctrl_awvalid && s_axi_ctrl_wvalid && !s_axi_ctrl_bvalid |=> s_axi_ctrl_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write not answered");

    property p_stream_rate;
        src_fire && !src_last && (fifo_level < CW'(FIFO_DEPTH - 1)) |=> in_ready;
    endproperty
    a_stream_rate: assert property (p_stream_rate) else $error("intake stalled mid line");

    property p_level_cap;
        fifo_level <= CW'(FIFO_DEPTH);
    endproperty
    a_level_cap: assert property (p_level_cap) else $error("level above depth");

    property p_flush_to_gap;
        (st_ff == VSTP_FLUSH) && (cnt_ff == '0) |=> (st_ff == VSTP_GAP) && (cnt_ff == GAP_LAST);
    endproperty
    a_flush_to_gap: assert property (p_flush_to_gap) else $error("gap not entered");

    property p_gap_to_run;
        (st_ff == VSTP_GAP) && (cnt_ff == '0) |=> (st_ff == VSTP_RUN);
    endproperty
    a_gap_to_run: assert property (p_gap_to_run) else $error("run not resumed");

    property p_st_legal;
        (st_ff == VSTP_RUN) || (st_ff == VSTP_FLUSH) || (st_ff == VSTP_GAP);
    endproperty
    a_st_legal: assert property (p_st_legal) else $error("illegal state");

    property p_fill_lat;
        src_fire && (fifo_level == '0) |-> ##2 fifo_out.valid;
    endproperty
    a_fill_lat: assert property (p_fill_lat) else $error("fill latency wrong");

    property p_load_out;
        !m_axis_video_tvalid && fifo_out.valid |=> m_axis_video_tvalid;
    endproperty
    a_load_out: assert property (p_load_out) else $error("output not loaded");

    property p_rd_resp;
        s_axi_ctrl_arvalid && !s_axi_ctrl_rvalid |=> s_axi_ctrl_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read not answered");

    property p_b_clear;
        s_axi_ctrl_bvalid && s_axi_ctrl_bready |=> !s_axi_ctrl_bvalid;
    endproperty
    a_b_clear: assert property (p_b_clear) else $error("write answer stuck");

    property p_rd_zero;
        s_axi_ctrl_rvalid |-> (s_axi_ctrl_rdata == 32'h0000_0000)
            && (s_axi_ctrl_rresp == `VSTP_RESP_OKAY);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read not zero okay");

    c_line_end: cover property (src_fire && src_last);
    c_full: cover property (fifo_level == CW'(FIFO_DEPTH));
    c_stall: cover property (m_axis_video_tvalid && !m_axis_video_tready);
    c_b2b: cover property (src_fire ##1 src_fire ##1 src_fire);
    c_ctrl: cover property (s_axi_ctrl_bvalid && s_axi_ctrl_rvalid);
endmodule : vstp_top
